//--- include/fesm_consts.svh
`ifndef FESM_CONSTS_SVH
`define FESM_CONSTS_SVH

// Register indices; byte address is four times the index
`define FESM_IDX_FT_STATUS   6'h1c
`define FESM_IDX_FT_MASK     6'h1d
`define FESM_IDX_ES_STATUS   6'h1e
`define FESM_IDX_ES_MASK     6'h1f
`define FESM_IDX_H1_STATUS   6'h20
`define FESM_IDX_H1_MASK     6'h21
`define FESM_IDX_H2_STATUS   6'h22
`define FESM_IDX_H2_MASK     6'h23
`define FESM_IDX_H1_RX_HIGH  6'h28
`define FESM_IDX_H1_TX_LOW   6'h29
`define FESM_IDX_H2_RX_HIGH  6'h2a
`define FESM_IDX_H2_TX_LOW   6'h2b
`define FESM_IDX_CTRL        6'h2c

// Frame timing status bits
`define FESM_BIT_RX_MF       2
`define FESM_BIT_RX_CRC_MF   1
`define FESM_BIT_RX_ALIGN    0

// Elastic store status bits
`define FESM_BIT_TX_ES_FULL  5
`define FESM_BIT_TX_ES_EMPTY 4
`define FESM_BIT_TX_SLIP     3
`define FESM_BIT_RX_ES_FULL  2
`define FESM_BIT_RX_ES_EMPTY 1
`define FESM_BIT_RX_SLIP     0

// HDLC status bits
`define FESM_BIT_TX_MSG_END  6
`define FESM_BIT_RX_PKT_END  5
`define FESM_BIT_RX_PKT_ST   4
`define FESM_BIT_RX_HIGH     3
`define FESM_BIT_RX_DATA     2
`define FESM_BIT_TX_LOW      1
`define FESM_BIT_TX_ROOM     0

// Control register bits
`define FESM_BIT_E1_MODE     0
`define FESM_BIT_CRC4_EN     1

`define FESM_RESET_BYTE      8'h00
`define FESM_FIFO_DEPTH      8'h80

// Free-running CRC4 multiframe period
`define FESM_CRC4_FREE_US    2000
`define FESM_CLK_MHZ         50
`define FESM_CRC4_FREE_CYC   (`FESM_CRC4_FREE_US * `FESM_CLK_MHZ)
`define FESM_FREE_CNT_W      17

`endif

//--- include/fesm_pkg.sv
package fesm_pkg;
   typedef logic [7:0] fesm_byte_t;
   typedef logic [5:0] fesm_idx_t;
   typedef logic [7:0] fesm_count_t;
endpackage : fesm_pkg

//--- rtl/fesm_top.sv
`timescale 1ns/10ps
`include "fesm_consts.svh"
module fesm_top
   import fesm_pkg::*;
#(
   parameter int unsigned CRC4_FREE_CYCLES = `FESM_CRC4_FREE_CYC
) (
   input  wire logic                  hclk,           // Bus clock
   input  wire logic                  hresetn,        // Async reset
   input  wire logic                  hsel,           // Slave select
   input  wire logic [7:0]            haddr,          // Byte address
   input  wire logic [1:0]            htrans,         // Transfer type
   input  wire logic                  hwrite,         // Write access
   input  wire logic [2:0]            hsize,          // Word only
   input  wire logic [31:0]           hwdata,         // Write data
   input  wire logic                  hready,         // Bus ready
   output logic [31:0]                hrdata,         // Read data
   output logic                       hreadyout,      // Slave ready
   output logic                       hresp,          // Always OKAY
   input  wire logic                  rx_mf_pulse,    // Rx MF boundary
   input  wire logic                  rx_crc_mf_pulse,// CRC4 MF boundary
   input  wire logic                  rx_align_pulse, // Align frame start
   input  wire logic                  tx_es_delete,   // Tx frame deleted
   input  wire logic                  tx_es_repeat,   // Tx frame repeated
   input  wire logic                  rx_es_delete,   // Rx frame deleted
   input  wire logic                  rx_es_repeat,   // Rx frame repeated
   input  wire logic [1:0]            tx_msg_done,    // Message sent
   input  wire logic [1:0]            rx_pkt_done,    // Packet ended
   input  wire logic [1:0]            rx_open_byte,   // Opening byte
   input  wire fesm_pkg::fesm_count_t rx_fifo_cnt [2],// Rx FIFO fill
   input  wire fesm_pkg::fesm_count_t tx_fifo_cnt [2],// Tx FIFO fill
   output logic                       irq_out         // Interrupt request
);
   import fesm_pkg::*;

   fesm_byte_t ft_status_reg;
   fesm_byte_t ft_mask_reg;
   fesm_byte_t es_status_reg;
   fesm_byte_t es_mask_reg;
   fesm_byte_t hdlc_mask_reg [2];
   fesm_byte_t rx_high_mark_level [2];
   fesm_byte_t tx_low_mark_level [2];
   logic [1:0] ctrl_reg;
   logic       wr_pend_reg;
   fesm_idx_t  wr_idx_reg;
   logic [`FESM_FREE_CNT_W-1:0] free_cnt_reg;
   logic       free_tick;
   logic       e1_mode;
   logic       crc4_en;
   logic       rd_fire;
   logic       wr_fire;
   fesm_idx_t  acc_idx;
   logic       ft_clr;
   logic       es_clr;
   logic [1:0] hdlc_clr;
   fesm_byte_t hdlc_stat [2];
   logic [1:0] hdlc_irq;
   fesm_byte_t rd_next;
   fesm_byte_t ft_set;
   fesm_byte_t es_set;

   assign e1_mode = ctrl_reg[`FESM_BIT_E1_MODE];
   assign crc4_en = ctrl_reg[`FESM_BIT_CRC4_EN];

   // Bus access decode on the address phase
   assign acc_idx = haddr[7:2];
   assign rd_fire = hsel & hready & htrans[1] & ~hwrite;
   assign wr_fire = hsel & hready & htrans[1] & hwrite;
   assign ft_clr  = rd_fire && (acc_idx == `FESM_IDX_FT_STATUS);
   assign es_clr  = rd_fire && (acc_idx == `FESM_IDX_ES_STATUS);

   // Free-running CRC4 multiframe when CRC4 is off
   assign free_tick =
      (free_cnt_reg == `FESM_FREE_CNT_W'(CRC4_FREE_CYCLES - 1));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         free_cnt_reg <= '0;
      end else if (free_tick) begin
         free_cnt_reg <= '0;
      end else begin
         free_cnt_reg <= free_cnt_reg + 1'b1;
      end
   end

   // Frame timing event sources
   always_comb begin
      ft_set = '0;
      ft_set[`FESM_BIT_RX_MF] = rx_mf_pulse;
      ft_set[`FESM_BIT_RX_CRC_MF] = e1_mode &
         (crc4_en ? rx_crc_mf_pulse : free_tick);
      ft_set[`FESM_BIT_RX_ALIGN] = e1_mode & rx_align_pulse;
   end

   // Elastic store slip sources
   always_comb begin
      es_set = '0;
      es_set[`FESM_BIT_TX_ES_FULL]  = tx_es_delete;
      es_set[`FESM_BIT_TX_ES_EMPTY] = tx_es_repeat;
      es_set[`FESM_BIT_TX_SLIP] = tx_es_delete | tx_es_repeat;
      es_set[`FESM_BIT_RX_ES_FULL]  = rx_es_delete;
      es_set[`FESM_BIT_RX_ES_EMPTY] = rx_es_repeat;
      es_set[`FESM_BIT_RX_SLIP] = rx_es_delete | rx_es_repeat;
   end

   // Set wins over a read clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ft_status_reg <= `FESM_RESET_BYTE;
      end else begin
         ft_status_reg <= (ft_clr ? '0 : ft_status_reg) | ft_set;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         es_status_reg <= `FESM_RESET_BYTE;
      end else begin
         es_status_reg <= (es_clr ? '0 : es_status_reg) | es_set;
      end
   end

   // Per-controller HDLC status
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_hdlc
         logic [2:0] evt_reg;
         logic [3:0] cond;
         logic [3:0] cond_prev_reg;
         logic [3:0] rise_reg;
         logic [2:0] evt_set;
         logic [3:0] rise_set;
         fesm_idx_t  stat_idx;

         assign stat_idx = `FESM_IDX_H1_STATUS + 6'(2 * g);
         assign hdlc_clr[g] = rd_fire && (acc_idx == stat_idx);

         assign cond[`FESM_BIT_RX_HIGH] =
            rx_fifo_cnt[g] > rx_high_mark_level[g];
         assign cond[`FESM_BIT_RX_DATA] =
            rx_fifo_cnt[g] != 8'h00;
         assign cond[`FESM_BIT_TX_LOW] =
            tx_fifo_cnt[g] < tx_low_mark_level[g];
         assign cond[`FESM_BIT_TX_ROOM] =
            tx_fifo_cnt[g] < `FESM_FIFO_DEPTH;

         assign evt_set = {tx_msg_done[g],
                           rx_pkt_done[g],
                           rx_open_byte[g]};

         // Falling edges never raise a request
         assign rise_set = cond & ~cond_prev_reg;

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               evt_reg <= '0;
            end else begin
               evt_reg <= (hdlc_clr[g] ? '0 : evt_reg) | evt_set;
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cond_prev_reg <= '0;
            end else begin
               cond_prev_reg <= cond;
            end
         end

         // Hidden sticky edges; read of the status clears them
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               rise_reg <= '0;
            end else begin
               rise_reg <= (hdlc_clr[g] ? '0 : rise_reg) | rise_set;
            end
         end

         assign hdlc_stat[g] = {1'b0, evt_reg, cond};
         assign hdlc_irq[g] =
            |({evt_reg, rise_reg} & hdlc_mask_reg[g][6:0]);
      end
   endgenerate

   // Write data phase follows the captured address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= '0;
      end else begin
         if (hready) begin
            wr_pend_reg <= wr_fire;
            wr_idx_reg  <= acc_idx;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ft_mask_reg           <= `FESM_RESET_BYTE;
         es_mask_reg           <= `FESM_RESET_BYTE;
         hdlc_mask_reg[0]      <= `FESM_RESET_BYTE;
         hdlc_mask_reg[1]      <= `FESM_RESET_BYTE;
         rx_high_mark_level[0] <= `FESM_RESET_BYTE;
         rx_high_mark_level[1] <= `FESM_RESET_BYTE;
         tx_low_mark_level[0]  <= `FESM_RESET_BYTE;
         tx_low_mark_level[1]  <= `FESM_RESET_BYTE;
         ctrl_reg              <= '0;
      end else if (wr_pend_reg) begin
         case (wr_idx_reg)
            `FESM_IDX_FT_MASK:    ft_mask_reg <= hwdata[7:0];
            `FESM_IDX_ES_MASK:    es_mask_reg <= hwdata[7:0];
            `FESM_IDX_H1_MASK:    hdlc_mask_reg[0] <= hwdata[7:0];
            `FESM_IDX_H2_MASK:    hdlc_mask_reg[1] <= hwdata[7:0];
            `FESM_IDX_H1_RX_HIGH: rx_high_mark_level[0] <= hwdata[7:0];
            `FESM_IDX_H1_TX_LOW:  tx_low_mark_level[0] <= hwdata[7:0];
            `FESM_IDX_H2_RX_HIGH: rx_high_mark_level[1] <= hwdata[7:0];
            `FESM_IDX_H2_TX_LOW:  tx_low_mark_level[1] <= hwdata[7:0];
            `FESM_IDX_CTRL:       ctrl_reg <= hwdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // Read value picked in the address phase, so a clear-on-read
   // returns the flags as they stood before the clear
   always_comb begin
      case (acc_idx)
         `FESM_IDX_FT_STATUS:  rd_next = ft_status_reg;
         `FESM_IDX_FT_MASK:    rd_next = ft_mask_reg;
         `FESM_IDX_ES_STATUS:  rd_next = es_status_reg;
         `FESM_IDX_ES_MASK:    rd_next = es_mask_reg;
         `FESM_IDX_H1_STATUS:  rd_next = hdlc_stat[0];
         `FESM_IDX_H1_MASK:    rd_next = hdlc_mask_reg[0];
         `FESM_IDX_H2_STATUS:  rd_next = hdlc_stat[1];
         `FESM_IDX_H2_MASK:    rd_next = hdlc_mask_reg[1];
         `FESM_IDX_H1_RX_HIGH: rd_next = rx_high_mark_level[0];
         `FESM_IDX_H1_TX_LOW:  rd_next = tx_low_mark_level[0];
         `FESM_IDX_H2_RX_HIGH: rd_next = rx_high_mark_level[1];
         `FESM_IDX_H2_TX_LOW:  rd_next = tx_low_mark_level[1];
         `FESM_IDX_CTRL:       rd_next = {6'h00, ctrl_reg};
         default:              rd_next = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_fire) begin
         hrdata <= {24'h00_0000, rd_next};
      end
   end

   // Zero-wait slave, never an error answer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(ft_status_reg & ft_mask_reg) |
                    |(es_status_reg & es_mask_reg) |
                    |hdlc_irq;
      end
   end

endmodule : fesm_top

//--- tb/fesm_host.sv
`timescale 1ns/10ps
module fesm_host
   import fesm_pkg::*;
(
   input  wire logic        hclk,      // Bus clock
   input  wire logic        hreadyout, // Slave ready
   input  wire logic [31:0] hrdata,    // Read data
   output logic             hsel,      // Slave select
   output logic [7:0]       haddr,     // Byte address
   output logic [1:0]       htrans,    // Transfer type
   output logic             hwrite,    // Write flag
   output logic [2:0]       hsize,     // Word size
   output logic [31:0]      hwdata     // Write data
);
   initial begin
      {hsel, htrans, hwrite, haddr, hwdata} = '0;
      hsize = 3'h2;
   end

   // Single word transfer; waits as long as the slave stalls
   task automatic xfer(input logic wr, input fesm_idx_t idx,
                       input fesm_byte_t wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {idx, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      haddr  <= ~haddr;
      hwdata <= {24'h00_0000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      // Released data lines wander so stale values never look valid
      hwdata <= ~hwdata;
   endtask : xfer
endmodule : fesm_host

//--- tb/fesm_top_props.sv
`timescale 1ns/10ps
`include "fesm_consts.svh"
module fesm_checker
   import fesm_pkg::*;
#(
   parameter int unsigned CRC4_FREE_CYCLES = `FESM_CRC4_FREE_CYC
) (
   input wire logic hclk, input wire logic hresetn, input wire logic hsel,
   input wire logic [7:0] haddr, input wire logic [1:0] htrans,
   input wire logic hwrite, input wire logic hready,
   input wire logic [31:0] hrdata, input wire logic irq_out,
   input wire logic rx_mf_pulse, input wire logic rx_crc_mf_pulse,
   input wire logic rx_align_pulse, input wire logic tx_es_delete,
   input wire logic tx_es_repeat, input wire logic rx_es_delete,
   input wire logic rx_es_repeat, input wire logic [1:0] tx_msg_done,
   input wire logic [1:0] rx_pkt_done, input wire logic [1:0] rx_open_byte,
   input wire fesm_pkg::fesm_count_t rx_fifo_cnt [2],
   input wire fesm_pkg::fesm_count_t tx_fifo_cnt [2]
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic tk, rd_es, rd_h1, rd_h2, cause, wrote;
   logic [3:0] hist;
   fesm_count_t rq [2], tq [2];
   assign tk = hsel && hready && htrans[1];
   assign rd_es = tk && !hwrite && haddr[7:2] == `FESM_IDX_ES_STATUS;
   assign rd_h1 = tk && !hwrite && haddr[7:2] == `FESM_IDX_H1_STATUS;
   assign rd_h2 = tk && !hwrite && haddr[7:2] == `FESM_IDX_H2_STATUS;
   // Any input event or bus write that may legally raise the request a few edges later
   assign cause = |{rx_mf_pulse, rx_crc_mf_pulse, rx_align_pulse,
      tx_es_delete, tx_es_repeat, rx_es_delete, rx_es_repeat, tx_msg_done,
      rx_pkt_done, rx_open_byte} || (tk && hwrite) || rx_fifo_cnt != rq
      || tx_fifo_cnt != tq;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wrote <= 1'b0;
         hist  <= 4'h0;
         rq    <= '{default: 8'h00};
         tq    <= '{default: 8'h00};
      end else begin
         wrote <= wrote | (tk & hwrite);
         hist  <= {hist[2:0], cause};
         rq    <= rx_fifo_cnt;
         tq    <= tx_fifo_cnt;
      end
   end
   property p_quiet; !wrote |-> !irq_out; endproperty
   a_quiet: assert property (p_quiet)
      else $error("interrupt before any mask write");
   property p_cause; $rose(irq_out) |-> hist != 4'h0; endproperty
   a_cause: assert property (p_cause)
      else $error("interrupt rose without a cause");
   property p_tx_delete;
      tx_es_delete ##1 !rd_es ##1 rd_es |=> hrdata[5] && hrdata[3];
   endproperty
   a_tx_delete: assert property (p_tx_delete)
      else $error("tx delete flags missing");
   property p_rx_repeat;
      rx_es_repeat ##1 !rd_es ##1 rd_es |=> hrdata[1] && hrdata[0];
   endproperty
   a_rx_repeat: assert property (p_rx_repeat)
      else $error("rx repeat flags missing");
   property p_pkt_end; rx_pkt_done[1] ##1 rd_h2 |=> hrdata[5]; endproperty
   a_pkt_end: assert property (p_pkt_end)
      else $error("packet end flag missing");
   property p_pkt_start; rx_open_byte[0] ##1 rd_h1 |=> hrdata[4]; endproperty
   a_pkt_start: assert property (p_pkt_start)
      else $error("packet start flag missing");
   property p_clear;
      rd_h1 && !tx_msg_done[0] ##1 !tx_msg_done[0]
         ##1 rd_h1 && !tx_msg_done[0] |=> !hrdata[6];
   endproperty
   a_clear: assert property (p_clear)
      else $error("message end flag not cleared by read");
   property p_not_empty;
      rd_h1 && $stable(rx_fifo_cnt[0])
         |=> hrdata[2] == ($past(rx_fifo_cnt[0]) != 8'h00);
   endproperty
   a_not_empty: assert property (p_not_empty)
      else $error("not empty bit wrong");
   property p_has_room;
      rd_h1 && $stable(tx_fifo_cnt[0])
         |=> hrdata[0] == ($past(tx_fifo_cnt[0]) < 8'h80);
   endproperty
   a_has_room: assert property (p_has_room)
      else $error("not full bit wrong");
endmodule : fesm_checker

bind fesm_top fesm_checker #(.CRC4_FREE_CYCLES(CRC4_FREE_CYCLES)) i_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .irq_out(irq_out), .rx_mf_pulse(rx_mf_pulse),
   .rx_crc_mf_pulse(rx_crc_mf_pulse), .rx_align_pulse(rx_align_pulse),
   .tx_es_delete(tx_es_delete), .tx_es_repeat(tx_es_repeat),
   .rx_es_delete(rx_es_delete), .rx_es_repeat(rx_es_repeat),
   .tx_msg_done(tx_msg_done), .rx_pkt_done(rx_pkt_done),
   .rx_open_byte(rx_open_byte), .rx_fifo_cnt(rx_fifo_cnt),
   .tx_fifo_cnt(tx_fifo_cnt));

//--- tb/fesm_top_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
   n_errors++; $display("unexpected at %0t: got %h expected %h", \
   $time, g, e); end end
module fesm_top_bench;
   import fesm_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp, irq_out;
   logic [7:0]  haddr;
   logic [1:0]  htrans, msg = 2'h0, pkt = 2'h0, opn = 2'h0;
   logic [2:0]  hsize, ft_in = 3'h0;
   logic [3:0]  es_in = 4'h0;
   logic [31:0] hwdata, hrdata;
   fesm_count_t rxc [2] = '{8'h00, 8'h00};
   fesm_count_t txc [2] = '{8'h00, 8'h00};
   int          n_errors = 0;
   int          check_count = 0;

   fesm_top #(.CRC4_FREE_CYCLES(50)) i_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .rx_mf_pulse(ft_in[2]),
      .rx_crc_mf_pulse(ft_in[1]), .rx_align_pulse(ft_in[0]),
      .tx_es_delete(es_in[3]), .tx_es_repeat(es_in[2]),
      .rx_es_delete(es_in[1]), .rx_es_repeat(es_in[0]),
      .tx_msg_done(msg), .rx_pkt_done(pkt), .rx_open_byte(opn),
      .rx_fifo_cnt(rxc), .tx_fifo_cnt(txc), .irq_out(irq_out));
   fesm_host i_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));

   initial begin
      forever #10 hclk = ~hclk;
   end
   // Whole run is well under a thousand cycles
   initial begin
      #100_000;
      n_errors++;
      stop_test();
   end

   task automatic wr(input fesm_idx_t idx, input fesm_byte_t d);
      logic [31:0] r;
      i_host.xfer(1'b1, idx, d, r);
   endtask : wr
   task automatic rd(input fesm_idx_t idx, input fesm_byte_t e);
      logic [31:0] r;
      i_host.xfer(1'b0, idx, 8'h00, r);
      `CHK(r, 32'(e))
      `CHK(hresp, 1'b0)
   endtask : rd
   task automatic irq_is(input logic e);
      @(posedge hclk);
      #1;
      `CHK(irq_out, e)
   endtask : irq_is

   task automatic t_reset;
      fesm_idx_t m [4] = '{6'h1d, 6'h1f, 6'h21, 6'h23};
      rd(6'h1c, 8'h00);
      rd(6'h1e, 8'h00);
      rd(6'h20, 8'h01);
      rd(6'h22, 8'h01);
      foreach (m[i]) begin
         rd(m[i], 8'h00);
         wr(m[i], 8'h35);
         rd(m[i], 8'h35);
         wr(m[i], 8'h00);
      end
      wr(6'h3f, 8'hff);
      rd(6'h3f, 8'h00);
   endtask : t_reset

   task automatic t_es;
      fesm_byte_t ex [4] = '{8'h28, 8'h18, 8'h05, 8'h03};
      wr(6'h1f, 8'h3f);
      for (int i = 0; i < 4; i++) begin
         es_in <= 4'b1000 >> i;
         @(posedge hclk);
         es_in <= 4'h0;
         irq_is(1'b1);
         rd(6'h1e, ex[i]);
         irq_is(1'b0);
      end
      // Only the transmit slip source left enabled
      wr(6'h1f, 8'h08);
      es_in <= 4'b0010;
      @(posedge hclk);
      es_in <= 4'h0;
      irq_is(1'b0);
      irq_is(1'b0);
      rd(6'h1e, 8'h05);
      wr(6'h1f, 8'h00);
   endtask : t_es

   task automatic t_frame;
      wr(6'h2c, 8'h01);
      wr(6'h1d, 8'h07);
      ft_in <= 3'b101;
      @(posedge hclk);
      ft_in <= 3'b000;
      repeat (60) @(posedge hclk);
      wr(6'h2c, 8'h00);
      rd(6'h1c, 8'h07);
      ft_in <= 3'b111;
      @(posedge hclk);
      ft_in <= 3'b000;
      rd(6'h1c, 8'h04);
      wr(6'h2c, 8'h03);
      ft_in <= 3'b011;
      @(posedge hclk);
      ft_in <= 3'b000;
      repeat (60) @(posedge hclk);
      rd(6'h1c, 8'h03);
      wr(6'h1d, 8'h00);
   endtask : t_frame

   task automatic t_hdlc;
      wr(6'h21, 8'h70);
      {msg, pkt, opn} <= 6'b01_0101;
      @(posedge hclk);
      {msg, pkt, opn} <= 6'h00;
      rd(6'h20, 8'h71);
      rd(6'h20, 8'h01);
      pkt <= 2'b10;
      @(posedge hclk);
      pkt <= 2'b00;
      rd(6'h22, 8'h21);
      wr(6'h28, 8'h10);
      wr(6'h29, 8'h08);
      rxc[0] <= 8'h10;
      txc[0] <= 8'h08;
      repeat (2) @(posedge hclk);
      rd(6'h20, 8'h05);
      rxc[0] <= 8'h11;
      txc[0] <= 8'h07;
      repeat (2) @(posedge hclk);
      rd(6'h20, 8'h0f);
      rxc[0] <= 8'h00;
      txc[0] <= 8'h80;
      repeat (2) @(posedge hclk);
      rd(6'h20, 8'h00);
      wr(6'h21, 8'h04);
      rd(6'h20, 8'h00);
      irq_is(1'b0);
      rxc[0] <= 8'h05;
      repeat (3) @(posedge hclk);
      irq_is(1'b1);
      rd(6'h20, 8'h04);
      irq_is(1'b0);
      rxc[0] <= 8'h00;
      repeat (3) @(posedge hclk);
      irq_is(1'b0);
      wr(6'h21, 8'h00);
   endtask : t_hdlc

   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_es();
      t_frame();
      t_hdlc();
      stop_test();
   end
endmodule : fesm_top_bench
